// file: design/sms_pkg.sv
// constants and types for the servo motion supervisor
// Function
// - target held as absolute or relative count
// - relative target added at motion start
// - max velocity is 16.16 counts per loop
// - accel and decel are 16.16 per loop squared
// - loop interval down to 62.5 us
// - jerk 0..1000 used only for bezier
// - start copies all buffered params atomically
// - trapezoid accepts restart while running
// - streaming starts once buffer level reached
// - smooth stop: trapezoid, target from deceleration
// - abrupt stop uses 32 times deceleration
// - servo-off stop shorts motor windings
// - thermal integral of current squared minus nominal
// - overheat flag follows integral over limit
// - overcurrent dwell sets flag, servo off
// - optional amplifier fault check, default off
// - following error dwell stops motion, flags
// - auto-stop mode also turns servo off
// - masked inputs inhibit servo and amplifier
// - bus undervoltage flag
// - bus overvoltage flag
// - inverter fault forces pwm high impedance
// - unmasked flags stop the motor
`default_nettype none
package sms_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_CMD      = 8'h04;
   localparam logic [7:0] ADDR_TARGET   = 8'h08;
   localparam logic [7:0] ADDR_DIST     = 8'h0C;
   localparam logic [7:0] ADDR_VEL      = 8'h10;
   localparam logic [7:0] ADDR_ACC      = 8'h14;
   localparam logic [7:0] ADDR_DEC      = 8'h18;
   localparam logic [7:0] ADDR_JERK     = 8'h1C;
   localparam logic [7:0] ADDR_GAIN     = 8'h20;
   localparam logic [7:0] ADDR_TH_NOM   = 8'h24;
   localparam logic [7:0] ADDR_TH_LIM   = 8'h28;
   localparam logic [7:0] ADDR_TC_LIM   = 8'h2C;
   localparam logic [7:0] ADDR_TC_DWELL = 8'h30;
   localparam logic [7:0] ADDR_FE_LIM   = 8'h34;
   localparam logic [7:0] ADDR_FE_TIME  = 8'h38;
   localparam logic [7:0] ADDR_VBUS     = 8'h3C;
   localparam logic [7:0] ADDR_MASKS    = 8'h40;
   localparam logic [7:0] ADDR_STATUS   = 8'h44;
   localparam logic [7:0] ADDR_POS      = 8'h48;
   localparam logic [7:0] ADDR_W_TGT    = 8'h4C;
   localparam logic [7:0] ADDR_W_DEC    = 8'h50;
   localparam logic [7:0] ADDR_THERM    = 8'h54;
   // ctrl fields
   localparam int CTRL_SERVO_ON  = 0;
   localparam int CTRL_AMP_CHK   = 1;
   localparam int CTRL_AUTO_OFF  = 2;
   localparam int CTRL_PROF_LSB  = 4;
   localparam int CTRL_PVT_LSB   = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // cmd codes
   localparam logic [2:0] CMD_GO     = 3'h1;
   localparam logic [2:0] CMD_GO_REL = 3'h2;
   localparam logic [2:0] CMD_SMOOTH = 3'h3;
   localparam logic [2:0] CMD_ABRUPT = 3'h4;
   localparam logic [2:0] CMD_SVOFF  = 3'h5;
   // status bits
   localparam int ST_OVERHEAT = 0;
   localparam int ST_OVERCUR  = 1;
   localparam int ST_AMPFLT   = 2;
   localparam int ST_FOLLOW   = 3;
   localparam int ST_INHIBIT  = 4;
   localparam int ST_UNDERV   = 5;
   localparam int ST_OVERV    = 6;
   localparam int ST_INVFLT   = 7;
   localparam int ST_SERVO    = 8;
   localparam int ST_MOVING   = 9;
   localparam int ST_SHORTED  = 10;
   localparam int NFLAGS      = 8;
   localparam logic [31:0] JERK_MAX = 32'h0000_03E8;
   localparam int ABRUPT_SHIFT = 5;
   // timing
   localparam real CLK_MHZ     = 20.0;
   localparam real LOOP_US     = 62.5;
   localparam int  LOOP_CYCLES = int'(LOOP_US * CLK_MHZ);
   typedef enum logic [1:0] {PROF_TRAP, PROF_SPLINE, PROF_BEZIER, PROF_PVT} sms_prof_e;
   typedef enum {MV_IDLE, MV_WAIT_PVT, MV_RUN, MV_STOPPING} sms_mv_e;
endpackage
`default_nettype wire

// file: design/sms_supervisor.sv
// servo motion supervisor: parameter latch, start/stop, interlocks
//
// Design decisions made here: register access over APB and the register addresses.
`default_nettype none
module sms_supervisor #(
   parameter int unsigned LOOP_CNT = sms_pkg::LOOP_CYCLES
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // axis measurements
   input  wire logic signed [31:0] axis_position,
   input  wire logic signed [15:0] motor_current,
   input  wire logic signed [31:0] following_error,
   input  wire logic [15:0] bus_voltage,
   input  wire logic        vpg_busy,
   input  wire logic [15:0] pvt_level,
   // pins from outside
   input  wire logic [7:0]  digital_inputs,
   input  wire logic        amp_fault_in,
   input  wire logic        inverter_fault_in,
   // working set and control to loop and inverter
   output logic signed [31:0] work_target,
   output logic      [31:0] work_velocity,
   output logic      [31:0] work_accel,
   output logic      [31:0] work_decel,
   output logic      [31:0] work_jerk,
   output logic      [31:0] work_gain,
   output logic      [1:0]  work_profile,
   output logic             motion_start,
   output logic             servo_enable,
   output logic             windings_short,
   output logic             pwm_hiz
);
   import sms_pkg::*;

   // ==========================================
   // input synchronisers
   logic [7:0] din_s1, din_s2, din_s3, din_q;
   logic [1:0] flt_s1, flt_s2, flt_s3, flt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_s1 <= 8'h00; din_s2 <= 8'h00; din_s3 <= 8'h00; din_q <= 8'h00;
         flt_s1 <= 2'h0; flt_s2 <= 2'h0; flt_s3 <= 2'h0; flt_q <= 2'h0;
      end else begin
         din_s1 <= digital_inputs;
         din_s2 <= din_s1;
         din_s3 <= din_s2;
         flt_s1 <= {inverter_fault_in, amp_fault_in};
         flt_s2 <= flt_s1;
         flt_s3 <= flt_s2;
         for (int i = 0; i < 8; i++) if (din_s2[i] == din_s3[i]) din_q[i] <= din_s3[i];
         for (int i = 0; i < 2; i++) if (flt_s2[i] == flt_s3[i]) flt_q[i] <= flt_s3[i];
      end
   end

   // ==========================================
   // apb decode
   wire        wr_en  = psel & penable & pwrite;
   wire        rd_en  = psel & penable & ~pwrite;
   wire        wr_cmd = wr_en & (paddr == ADDR_CMD);
   wire [2:0]  cmd    = pwdata[2:0];

   // ==========================================
   // buffered parameters, host side only
   logic [31:0] ctrl_reg, tgt_buf, dist_buf, vel_buf, acc_buf, dec_buf, jerk_buf, gain_buf;
   logic [31:0] th_nom_reg, th_lim_reg, tc_lim_reg, tc_dwell_reg, fe_lim_reg, fe_time_reg;
   logic [31:0] vbus_reg, masks_reg;
   logic        rel_pending;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET; tgt_buf <= 32'h0; dist_buf <= 32'h0;
         vel_buf <= 32'h0; acc_buf <= 32'h0; dec_buf <= 32'h0; jerk_buf <= 32'h0;
         gain_buf <= 32'h0; th_nom_reg <= 32'h0; th_lim_reg <= 32'h7FFF_FFFF;
         tc_lim_reg <= 32'h0000_7FFF; tc_dwell_reg <= 32'h0; fe_lim_reg <= 32'h7FFF_FFFF;
         fe_time_reg <= 32'h0; vbus_reg <= 32'hFFFF_0000; masks_reg <= 32'h0;
         rel_pending <= 1'b0;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_CTRL:     ctrl_reg <= pwdata;
            ADDR_TARGET:   begin tgt_buf <= pwdata; rel_pending <= 1'b0; end
            ADDR_DIST:     begin dist_buf <= pwdata; rel_pending <= 1'b1; end
            ADDR_VEL:      vel_buf <= pwdata;
            ADDR_ACC:      acc_buf <= pwdata;
            ADDR_DEC:      dec_buf <= pwdata;
            ADDR_JERK:     jerk_buf <= (pwdata > JERK_MAX) ? JERK_MAX : pwdata;
            ADDR_GAIN:     gain_buf <= pwdata;
            ADDR_TH_NOM:   th_nom_reg <= pwdata;
            ADDR_TH_LIM:   th_lim_reg <= pwdata;
            ADDR_TC_LIM:   tc_lim_reg <= pwdata;
            ADDR_TC_DWELL: tc_dwell_reg <= pwdata;
            ADDR_FE_LIM:   fe_lim_reg <= pwdata;
            ADDR_FE_TIME:  fe_time_reg <= pwdata;
            ADDR_VBUS:     vbus_reg <= pwdata;
            ADDR_MASKS:    masks_reg <= pwdata;
            default:       ;
         endcase
      end
   end

   // ==========================================
   // loop interval tick
   logic [15:0] tick_cnt;
   wire         loop_tick = (tick_cnt == 16'(LOOP_CNT - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_cnt <= 16'h0000;
      else          tick_cnt <= loop_tick ? 16'h0000 : tick_cnt + 16'h0001;
   end

   // ==========================================
   // interlock evaluation
   logic signed [47:0] therm_reg;
   logic [31:0] tc_cnt, fe_cnt;
   logic [NFLAGS-1:0] flags_reg;
   wire signed [31:0] cur_sq   = 32'(motor_current * motor_current);
   wire signed [47:0] therm_nx = therm_reg + 48'(cur_sq) - 48'(signed'(th_nom_reg));
   wire [15:0] cur_abs  = motor_current[15] ? 16'(-motor_current) : 16'(motor_current);
   wire [31:0] fe_abs   = following_error[31] ? 32'(-following_error) : 32'(following_error);
   wire        tc_over  = cur_abs > tc_lim_reg[15:0];
   wire        fe_over  = fe_abs > fe_lim_reg;
   wire [7:0]  din_hit  = din_q & masks_reg[7:0];
   wire [7:0]  stop_msk = masks_reg[15:8];
   wire [7:0]  off_msk  = masks_reg[23:16];
   wire        amp_chk  = ctrl_reg[CTRL_AMP_CHK];
   wire        auto_off = ctrl_reg[CTRL_AUTO_OFF];
   logic [NFLAGS-1:0] ev;
   always_comb begin
      ev = '0;
      ev[ST_OVERHEAT] = therm_reg > 48'(signed'(th_lim_reg));
      ev[ST_OVERCUR]  = tc_over & (tc_cnt >= tc_dwell_reg);
      ev[ST_AMPFLT]   = amp_chk & flt_q[0];
      ev[ST_FOLLOW]   = fe_over & (fe_cnt >= fe_time_reg);
      ev[ST_INHIBIT]  = |din_hit;
      ev[ST_UNDERV]   = bus_voltage < vbus_reg[15:0];
      ev[ST_OVERV]    = bus_voltage > vbus_reg[31:16];
      ev[ST_INVFLT]   = flt_q[1];
   end
   // unmasked flags stop or shut off
   wire stop_req = |(flags_reg & stop_msk) | flags_reg[ST_OVERCUR] | flags_reg[ST_FOLLOW];
   wire off_req  = |(flags_reg & off_msk) | flags_reg[ST_OVERCUR] | flags_reg[ST_AMPFLT]
                   | flags_reg[ST_INHIBIT] | (flags_reg[ST_FOLLOW] & auto_off);
   wire clr_flags = wr_en & (paddr == ADDR_STATUS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         therm_reg <= 48'sh0; tc_cnt <= 32'h0; fe_cnt <= 32'h0; flags_reg <= '0;
      end else begin
         if (loop_tick) begin
            therm_reg <= therm_nx[47] ? 48'sh0 : therm_nx;
            tc_cnt    <= tc_over ? tc_cnt + 32'h1 : 32'h0;
            fe_cnt    <= fe_over ? fe_cnt + 32'h1 : 32'h0;
         end
         // overheat tracks level; others sticky, set wins over clear
         flags_reg <= ((clr_flags ? flags_reg & ~pwdata[NFLAGS-1:0] : flags_reg)
                       | (loop_tick ? ev : '0) | {flt_q[1], 7'h00});
         if (loop_tick) flags_reg[ST_OVERHEAT] <= ev[ST_OVERHEAT];
      end
   end

   // ==========================================
   // motion start and stop
   sms_mv_e mv_reg;
   wire [1:0] prof_sel  = ctrl_reg[CTRL_PROF_LSB +: 2];
   wire [15:0] pvt_thr  = ctrl_reg[CTRL_PVT_LSB +: 16];
   wire is_go  = wr_cmd & ((cmd == CMD_GO) | (cmd == CMD_GO_REL));
   wire go_ok  = is_go & servo_enable & ~stop_req
                 & ((mv_reg == MV_IDLE) | (work_profile == PROF_TRAP));
   wire pvt_go = (mv_reg == MV_WAIT_PVT) & (pvt_level >= pvt_thr);
   // interlock stop only from a live motion, else the decel shift would compound
   wire stop_go = (wr_cmd & (cmd == CMD_ABRUPT) & (mv_reg != MV_IDLE))
                  | (stop_req & ((mv_reg == MV_RUN) | (mv_reg == MV_WAIT_PVT)));
   wire signed [31:0] decel_dist = signed'(32'((64'(vel_buf) * 64'(vel_buf))
                                   / (64'(work_decel) + 64'h1) >> 17));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mv_reg <= MV_IDLE; work_target <= 32'sh0; work_velocity <= 32'h0;
         work_accel <= 32'h0; work_decel <= 32'h0; work_jerk <= 32'h0; work_gain <= 32'h0;
         work_profile <= PROF_TRAP; motion_start <= 1'b0; servo_enable <= 1'b0;
         windings_short <= 1'b0;
      end else begin
         motion_start <= 1'b0;
         if (wr_en & (paddr == ADDR_CTRL)) begin
            servo_enable <= pwdata[CTRL_SERVO_ON];
            if (pwdata[CTRL_SERVO_ON]) windings_short <= 1'b0;
         end
         if (go_ok) begin
            work_velocity <= vel_buf;
            work_accel    <= acc_buf;
            work_decel    <= dec_buf;
            work_jerk     <= (prof_sel == PROF_BEZIER) ? jerk_buf : 32'h0;
            work_gain     <= gain_buf;
            work_profile  <= prof_sel;
            work_target   <= (rel_pending | (cmd == CMD_GO_REL))
                             ? axis_position + signed'(dist_buf) : signed'(tgt_buf);
            mv_reg        <= (prof_sel == PROF_PVT) ? MV_WAIT_PVT : MV_RUN;
            motion_start  <= (prof_sel != PROF_PVT);
         end else if (pvt_go) begin
            mv_reg       <= MV_RUN;
            motion_start <= 1'b1;
         end else if (wr_cmd & (cmd == CMD_SMOOTH) & (mv_reg != MV_IDLE)) begin
            work_profile <= PROF_TRAP;
            work_target  <= axis_position + (work_target >= axis_position
                            ? decel_dist : -decel_dist);
            mv_reg       <= MV_STOPPING;
            motion_start <= 1'b1;
         end else if (stop_go) begin
            work_profile <= PROF_TRAP;
            work_decel   <= work_decel << ABRUPT_SHIFT;
            work_target  <= axis_position;
            mv_reg       <= MV_STOPPING;
            motion_start <= 1'b1;
         end else if ((mv_reg == MV_RUN | mv_reg == MV_STOPPING) & ~vpg_busy & ~motion_start) begin
            mv_reg <= MV_IDLE;
         end
         if (wr_cmd & (cmd == CMD_SVOFF)) begin
            servo_enable   <= 1'b0;
            windings_short <= 1'b1;
            mv_reg         <= MV_IDLE;
            motion_start   <= 1'b0;
         end
         if (off_req) begin
            servo_enable <= 1'b0;
            mv_reg       <= MV_IDLE;
            motion_start <= 1'b0;
         end
      end
   end

   assign pwm_hiz = flt_q[1] | flags_reg[ST_INHIBIT] | flags_reg[ST_INVFLT];

   // ==========================================
   // read mux
   wire [31:0] status_word = {21'h0, windings_short, (mv_reg != MV_IDLE), servo_enable, flags_reg};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (paddr)
         ADDR_CTRL:     rd_mux = ctrl_reg;
         ADDR_TARGET:   rd_mux = tgt_buf;
         ADDR_DIST:     rd_mux = dist_buf;
         ADDR_VEL:      rd_mux = vel_buf;
         ADDR_ACC:      rd_mux = acc_buf;
         ADDR_DEC:      rd_mux = dec_buf;
         ADDR_JERK:     rd_mux = jerk_buf;
         ADDR_GAIN:     rd_mux = gain_buf;
         ADDR_TH_NOM:   rd_mux = th_nom_reg;
         ADDR_TH_LIM:   rd_mux = th_lim_reg;
         ADDR_TC_LIM:   rd_mux = tc_lim_reg;
         ADDR_TC_DWELL: rd_mux = tc_dwell_reg;
         ADDR_FE_LIM:   rd_mux = fe_lim_reg;
         ADDR_FE_TIME:  rd_mux = fe_time_reg;
         ADDR_VBUS:     rd_mux = vbus_reg;
         ADDR_MASKS:    rd_mux = masks_reg;
         ADDR_STATUS:   rd_mux = status_word;
         ADDR_POS:      rd_mux = axis_position;
         ADDR_W_TGT:    rd_mux = work_target;
         ADDR_W_DEC:    rd_mux = work_decel;
         ADDR_THERM:    rd_mux = therm_reg[31:0];
         default:       rd_mux = 32'h0;
      endcase
   end
   wire mapped = (paddr <= ADDR_THERM) & (paddr[1:0] == 2'b00);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (psel & ~penable & ~pwrite) prdata <= rd_mux;
   end
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
endmodule
`default_nettype wire

// file: verification/sms_supervisor_chk.sv
// assertion checker for the servo motion supervisor ports
`default_nettype none
module sms_supervisor_chk
   import sms_pkg::*;
#(
   parameter int unsigned LOOP_CNT = 4
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   // pins and outputs
   input wire logic        inverter_fault_in,
   input wire logic [31:0] work_velocity,
   input wire logic [31:0] work_accel,
   input wire logic [31:0] work_jerk,
   input wire logic        motion_start,
   input wire logic        servo_enable,
   input wire logic        windings_short,
   input wire logic        pwm_hiz
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc    = psel && penable;
   wire cmd_wr = acc && pwrite && paddr == ADDR_CMD;
   // ==========================================
   // assertions
   AST_START_PULSE: assert property (motion_start |=> !motion_start)
      else $error("start pulse longer than one cycle");
   AST_START_SERVO: assert property (motion_start |-> servo_enable)
      else $error("motion started with servo off");
   AST_ATOMIC_VEL: assert property ($changed(work_velocity) |-> $past(cmd_wr))
      else $error("working velocity changed outside start");
   AST_ATOMIC_ACC: assert property ($changed(work_accel) || $changed(work_jerk)
      |-> $past(cmd_wr))
      else $error("working accel or jerk changed outside start");
   AST_JERK_MAX: assert property (work_jerk <= JERK_MAX)
      else $error("working jerk above limit");
   AST_INV_HIZ: assert property (inverter_fault_in |-> ##[0:6] pwm_hiz)
      else $error("inverter fault without high impedance");
   AST_SHORT_OFF: assert property (windings_short |-> !servo_enable)
      else $error("windings shorted with servo on");
   AST_SVOFF_CMD: assert property (cmd_wr && pwdata[2:0] == CMD_SVOFF
      |-> ##[1:3] (windings_short && !servo_enable))
      else $error("servo-off stop not carried out");
   AST_SLVERR_MAP: assert property (acc && paddr > ADDR_THERM |-> pslverr)
      else $error("unmapped access not refused");
   // ==========================================
   // covers
   COV_START: cover property (motion_start);
   COV_SHORT: cover property ($rose(windings_short));
   COV_HIZ: cover property ($rose(pwm_hiz));
endmodule
`default_nettype wire

// file: verification/sms_inverter_model.sv
// behavioural model of the inverter power stage
`default_nettype none
module sms_inverter_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // bench controls
   input  wire logic        fault_req,
   input  wire logic [15:0] bus_level,
   // to and from the supervisor
   input  wire logic        pwm_hiz,
   output logic             inverter_fault_in,
   output logic [15:0]      bus_voltage
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inverter_fault_in <= 1'b0;
         bus_voltage       <= 16'h0000;
      end else begin
         inverter_fault_in <= fault_req || (inverter_fault_in && !pwm_hiz);
         bus_voltage       <= bus_level;
      end
   end
endmodule
`default_nettype wire

// file: verification/test_sms_supervisor.sv
// testbench for the servo motion supervisor
`default_nettype none
module test_sms_supervisor;
   import sms_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LC = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, vpg_busy, fault_req;
   logic amp_fault_in, inverter_fault_in, motion_start, servo_enable, windings_short, pwm_hiz;
   logic [7:0] paddr, digital_inputs;
   logic [31:0] pwdata, prdata, work_velocity, work_accel, work_decel, work_jerk, work_gain, q;
   logic signed [31:0] axis_position, following_error, work_target;
   logic signed [15:0] motor_current;
   logic [15:0] bus_voltage, pvt_level, bus_level;
   logic [1:0] work_profile;
   logic err_seen;
   int errors, samples_checked, n_start;
   sms_supervisor #(.LOOP_CNT(LC)) sms_supervisor_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .axis_position, .motor_current,
      .following_error, .bus_voltage, .vpg_busy, .pvt_level, .digital_inputs, .amp_fault_in,
      .inverter_fault_in, .work_target, .work_velocity, .work_accel, .work_decel, .work_jerk,
      .work_gain, .work_profile, .motion_start, .servo_enable, .windings_short, .pwm_hiz);
   sms_inverter_model sms_inverter_model_i (.pclk, .presetn, .fault_req, .bus_level, .pwm_hiz,
      .inverter_fault_in, .bus_voltage);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) if (motion_start === 1'b1) n_start <= n_start + 1;
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err_seen = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic tick(input int n);
      repeat (n * LC) @(posedge pclk);
   endtask
   task automatic go(input logic [2:0] c);
      int n0;
      n0 = n_start;
      wr(ADDR_CMD, {29'h0, c});
      for (int i = 0; i < 40 && n_start == n0; i++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      chk(n_start, n0 + 1);
   endtask
   task automatic st(input int b, input logic e);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(q[b], e);
   endtask
   task automatic end_of_test();
      if (errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      end_of_test();
   end
   // ==========================================
   // tests
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, vpg_busy, fault_req, amp_fault_in} = '0;
      {axis_position, following_error, motor_current, pvt_level, digital_inputs} = '0;
      bus_level = 16'h0096; n_start = 0; errors = 0; samples_checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(work_velocity, 32'h0);
      xfer(1'b0, 8'h60, 32'h0); chk(q, 32'h0); chk(err_seen, 1'b1);
      wr(ADDR_VBUS, 32'h00C8_0064); wr(ADDR_TC_LIM, 32'h0000_0064); wr(ADDR_TC_DWELL, 32'h2);
      wr(ADDR_FE_LIM, 32'h0000_000A); wr(ADDR_FE_TIME, 32'h2); wr(ADDR_TH_LIM, 32'h0000_012C);
      wr(ADDR_STATUS, 32'h0000_00FF);
      // 5000 c/s and 30000 c/s2 at 125 us
      wr(ADDR_TARGET, 32'h0000_03E8); wr(ADDR_VEL, 32'h0000_A000); wr(ADDR_ACC, 32'h0000_001F);
      wr(ADDR_DEC, 32'h0000_0040); wr(ADDR_JERK, 32'h0000_07D0); wr(ADDR_GAIN, 32'h0000_1234);
      wr(ADDR_CTRL, 32'h0000_0021);
      chk(work_velocity, 32'h0);
      go(CMD_GO);
      chk(work_target, 32'h0000_03E8); chk(work_velocity, 32'h0000_A000);
      chk(work_accel, 32'h0000_001F); chk(work_decel, 32'h0000_0040);
      chk(work_jerk, JERK_MAX); chk(work_gain, 32'h0000_1234);
      chk(work_profile, PROF_BEZIER);
      wr(ADDR_CTRL, 32'h0000_0001);
      vpg_busy <= 1'b1;
      go(CMD_GO);
      chk(work_jerk, 32'h0); chk(work_profile, PROF_TRAP);
      wr(ADDR_DIST, 32'h0000_0064); axis_position <= 32'sd500; wr(ADDR_VEL, 32'h0000_B000);
      go(CMD_GO_REL);
      chk(work_target, 32'h0000_0258); chk(work_velocity, 32'h0000_B000);
      wr(ADDR_CMD, {29'h0, CMD_ABRUPT}); tick(2);
      xfer(1'b0, ADDR_W_DEC, 32'h0); chk(q, 32'h0000_0800);
      wr(ADDR_CMD, {29'h0, CMD_SMOOTH}); tick(2);
      chk(work_profile, PROF_TRAP); chk(work_target, 32'h0000_01FB);
      vpg_busy <= 1'b0;
      motor_current <= 16'sd10; tick(6); st(ST_OVERHEAT, 1'b1);
      wr(ADDR_TH_NOM, 32'h0000_03E8); motor_current <= 16'sd0; tick(4);
      st(ST_OVERHEAT, 1'b0);
      motor_current <= 16'sd200; tick(6); st(ST_OVERCUR, 1'b1);
      chk(servo_enable, 1'b0); motor_current <= 16'sd0;
      amp_fault_in <= 1'b1; tick(2); st(ST_AMPFLT, 1'b0);
      wr(ADDR_STATUS, 32'h0000_00FF); wr(ADDR_CTRL, 32'h0000_0003);
      tick(2); st(ST_AMPFLT, 1'b1);
      chk(servo_enable, 1'b0); amp_fault_in <= 1'b0;
      wr(ADDR_MASKS, 32'h0000_0001); wr(ADDR_CTRL, 32'h0000_0001); wr(ADDR_STATUS, 32'h0000_00FF);
      wr(ADDR_CTRL, 32'h0000_0001);
      digital_inputs <= 8'h01; tick(2); st(ST_INHIBIT, 1'b1);
      chk({servo_enable, pwm_hiz}, 2'b01); digital_inputs <= 8'h00;
      for (int i = 0; i < 2; i++) begin
         bus_level <= i ? 16'h00FA : 16'h0032; tick(2); st(i ? ST_OVERV : ST_UNDERV, 1'b1);
      end
      bus_level <= 16'h0096; tick(1);
      wr(ADDR_STATUS, 32'h0000_00FF); wr(ADDR_CTRL, 32'h0000_0005); st(ST_OVERV, 1'b0);
      following_error <= 32'sd50; tick(6); st(ST_FOLLOW, 1'b1);
      chk(servo_enable, 1'b0); following_error <= 32'sd0;
      fault_req <= 1'b1; tick(2); st(ST_INVFLT, 1'b1);
      chk(pwm_hiz, 1'b1); fault_req <= 1'b0; tick(2);
      wr(ADDR_STATUS, 32'h0000_00FF); wr(ADDR_CTRL, 32'h0000_0001); tick(1);
      chk(servo_enable, 1'b1);
      wr(ADDR_CMD, {29'h0, CMD_SVOFF}); repeat (3) @(posedge pclk);
      chk({windings_short, servo_enable}, 2'b10);
      end_of_test();
   end
endmodule
bind sms_supervisor sms_supervisor_chk #(.LOOP_CNT(LOOP_CNT)) sms_supervisor_chk_i (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .inverter_fault_in,
   .work_velocity, .work_accel, .work_jerk, .motion_start, .servo_enable, .windings_short,
   .pwm_hiz);
`default_nettype wire
